// ===== core/bidio_top.sv
// Bidirectional I/O port block with its AHB-Lite register slave.
//
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/100ps
module bidio_top (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [5:0]  first_port_pins_st,
  input  wire logic [5:0]  first_port_pins_ttl,
  output logic      [5:0]  first_port_pins_out,
  output logic      [5:0]  first_port_pins_oe,
  output logic      [5:0]  first_port_slew_limit,
  input  wire logic [7:0]  third_port_pins_in,
  output logic      [7:0]  third_port_pins_out,
  output logic      [7:0]  third_port_pins_oe,
  output logic      [7:0]  third_port_weak_pullup_on
);

  typedef struct packed {
    bidio_pkg::bidio_bus_e st;
    logic                  wr;
    logic [7:0]            addr;
    logic [31:0]           hrdata;
    logic                  hready;
    logic                  hresp;
    logic [5:0]            fp_dir;
    logic [5:0]            fp_lat;
    logic [5:0]            fp_od;
    logic [5:0]            fp_slew;
    logic [5:0]            fp_thr;
    logic [5:0]            fp_ans;
    logic [5:0]            slew_out;
    logic [7:0]            tp_dir;
    logic [7:0]            tp_lat;
    logic [7:0]            tp_ans;
    logic [7:0]            tp_wpu;
    logic                  gpd;
  } bidio_top_s;

  localparam bidio_top_s TOP_RST = '{
    st:       bidio_pkg::BIDIO_IDLE,
    wr:       1'b0,
    addr:     8'h00,
    hrdata:   32'h00000000,
    hready:   1'b1,
    hresp:    1'b0,
    fp_dir:   bidio_pkg::FP_DIR_RST,
    fp_lat:   bidio_pkg::FP_LAT_RST,
    fp_od:    bidio_pkg::FP_OD_RST,
    fp_slew:  bidio_pkg::FP_SLEW_RST,
    fp_thr:   bidio_pkg::FP_THR_RST,
    fp_ans:   bidio_pkg::FP_ANS_RST,
    slew_out: bidio_pkg::FP_SLEW_RST,
    tp_dir:   bidio_pkg::TP_DIR_RST,
    tp_lat:   bidio_pkg::TP_LAT_RST,
    tp_ans:   bidio_pkg::TP_ANS_RST,
    tp_wpu:   bidio_pkg::TP_WPU_RST,
    gpd:      bidio_pkg::GPD_RST
  };

  bidio_top_s  st_r;
  bidio_top_s  st_nxt;
  logic [5:0]  fp_st_s;
  logic [5:0]  fp_ttl_s;
  logic [7:0]  tp_in_s;
  logic [5:0]  fp_sel_in;
  logic [5:0]  fp_dig;
  logic [7:0]  tp_dig;
  logic [7:0]  rmw_fp;
  logic [7:0]  rmw_tp;
  logic [31:0] rd_word;
  logic        accept;
  logic        dphase;

  bidio_pad_if #(.W(bidio_pkg::FP_W)) fp_if ();
  bidio_pad_if #(.W(bidio_pkg::TP_W)) tp_if ();

  // All pin levels are asynchronous to mclk and pass two flip-flops first.
  bidio_sync #(.W(20)) u_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .d       ({first_port_pins_st, first_port_pins_ttl, third_port_pins_in}),
    .q       ({fp_st_s, fp_ttl_s, tp_in_s})
  );

  bidio_padctl #(.W(bidio_pkg::FP_W)) u_fp_pad (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .p       (fp_if.pad)
  );

  bidio_padctl #(.W(bidio_pkg::TP_W)) u_tp_pad (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .p       (tp_if.pad)
  );

  assign fp_if.dir    = st_r.fp_dir;
  assign fp_if.lat    = st_r.fp_lat;
  assign fp_if.od     = st_r.fp_od;
  assign fp_if.pu_sel = 6'h00;
  assign fp_if.gpd    = st_r.gpd;
  assign tp_if.dir    = st_r.tp_dir;
  assign tp_if.lat    = st_r.tp_lat;
  assign tp_if.od     = 8'h00;
  assign tp_if.pu_sel = st_r.tp_wpu;
  assign tp_if.gpd    = st_r.gpd;

  // A set threshold bit selects the Schmitt comparator, a clear one TTL.
  assign fp_sel_in = (st_r.fp_thr & fp_st_s) | (~st_r.fp_thr & fp_ttl_s);
  assign fp_dig    = fp_sel_in & ~st_r.fp_ans;
  assign tp_dig    = tp_in_s & ~st_r.tp_ans;

  // Analog pins feed zeros into the merge, so they can clear their latch bits.
  assign rmw_fp = bidio_pkg::bidio_rmw({2'h0, fp_dig}, hwdata[7:0],
                    hwdata[bidio_pkg::RMW_KEEP_LSB +: 8]);
  assign rmw_tp = bidio_pkg::bidio_rmw(tp_dig, hwdata[7:0],
                    hwdata[bidio_pkg::RMW_KEEP_LSB +: 8]);

  assign accept = hsel & htrans[1] & hready;
  assign dphase = (st_r.st == bidio_pkg::BIDIO_DATA);

  always_comb begin
    rd_word = 32'h00000000;
    case (st_r.addr)
      bidio_pkg::OFS_FP_PINS: rd_word[5:0] = fp_dig;
      bidio_pkg::OFS_FP_DIR:  rd_word[5:0] = st_r.fp_dir;
      bidio_pkg::OFS_FP_LAT:  rd_word[5:0] = st_r.fp_lat;
      bidio_pkg::OFS_FP_OD:   rd_word[5:0] = st_r.fp_od;
      bidio_pkg::OFS_FP_SLEW: rd_word[5:0] = st_r.fp_slew;
      bidio_pkg::OFS_FP_THR:  rd_word[5:0] = st_r.fp_thr;
      bidio_pkg::OFS_FP_ANS:  rd_word[5:0] = st_r.fp_ans;
      bidio_pkg::OFS_TP_PINS: rd_word[7:0] = tp_dig;
      bidio_pkg::OFS_TP_DIR:  rd_word[7:0] = st_r.tp_dir;
      bidio_pkg::OFS_TP_LAT:  rd_word[7:0] = st_r.tp_lat;
      bidio_pkg::OFS_TP_ANS:  rd_word[7:0] = st_r.tp_ans;
      bidio_pkg::OFS_TP_WPU:  rd_word[7:0] = st_r.tp_wpu;
      bidio_pkg::OFS_OPTION:  rd_word[bidio_pkg::GPD_BIT] = st_r.gpd;
      default:                rd_word = 32'h00000000;
    endcase
  end

  always_comb begin
    st_nxt          = st_r;
    st_nxt.hresp    = 1'b0;
    st_nxt.slew_out = st_r.fp_slew;
    unique case (st_r.st)
      bidio_pkg::BIDIO_IDLE: begin
        st_nxt.hready = 1'b1;
        if (accept) begin
          st_nxt.st     = bidio_pkg::BIDIO_DATA;
          st_nxt.wr     = hwrite;
          st_nxt.addr   = {haddr[7:2], 2'b00};
          st_nxt.hready = 1'b0;
        end
      end
      bidio_pkg::BIDIO_DATA: begin
        st_nxt.st     = bidio_pkg::BIDIO_IDLE;
        st_nxt.hready = 1'b1;
        if (st_r.wr) begin
          case (st_r.addr)
            bidio_pkg::OFS_FP_PINS: st_nxt.fp_lat = rmw_fp[5:0];
            // Pin three keeps its driver off whatever software writes.
            bidio_pkg::OFS_FP_DIR:  st_nxt.fp_dir = hwdata[5:0] | bidio_pkg::FP_IN_ONLY_MASK;
            bidio_pkg::OFS_FP_LAT:  st_nxt.fp_lat = hwdata[5:0];
            bidio_pkg::OFS_FP_OD:   st_nxt.fp_od = hwdata[5:0];
            bidio_pkg::OFS_FP_SLEW: st_nxt.fp_slew = hwdata[5:0];
            bidio_pkg::OFS_FP_THR:  st_nxt.fp_thr = hwdata[5:0];
            bidio_pkg::OFS_FP_ANS:  st_nxt.fp_ans = hwdata[5:0] & bidio_pkg::FP_ANS_MASK;
            bidio_pkg::OFS_TP_PINS: st_nxt.tp_lat = rmw_tp;
            bidio_pkg::OFS_TP_DIR:  st_nxt.tp_dir = hwdata[7:0];
            bidio_pkg::OFS_TP_LAT:  st_nxt.tp_lat = hwdata[7:0];
            bidio_pkg::OFS_TP_ANS:  st_nxt.tp_ans = hwdata[7:0] & bidio_pkg::TP_ANS_MASK;
            bidio_pkg::OFS_TP_WPU:  st_nxt.tp_wpu = hwdata[7:0];
            bidio_pkg::OFS_OPTION:  st_nxt.gpd = hwdata[bidio_pkg::GPD_BIT];
            default:                st_nxt.hresp = 1'b0;
          endcase
        end else begin
          st_nxt.hrdata = rd_word;
        end
      end
      default: begin
        st_nxt.st     = bidio_pkg::BIDIO_IDLE;
        st_nxt.hready = 1'b1;
      end
    endcase
  end

  // Analog select and pull-up bits come out of reset set, as do directions.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= TOP_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata                    = st_r.hrdata;
  assign hreadyout                 = st_r.hready;
  assign hresp                     = st_r.hresp;
  assign first_port_pins_out       = fp_if.out;
  assign first_port_pins_oe        = fp_if.oe;
  assign first_port_slew_limit     = st_r.slew_out;
  assign third_port_pins_out       = tp_if.out;
  assign third_port_pins_oe        = tp_if.oe;
  assign third_port_weak_pullup_on = tp_if.pu;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  a_pin_three_input: assert property (
    !first_port_pins_oe[3] && st_r.fp_dir[3])
    else $error("input-only pin three has its driver on");

  a_bus_one_wait: assert property (
    accept && !dphase |=> !hreadyout ##1 hreadyout)
    else $error("transfer not answered after exactly one wait state");

  a_hresp_okay: assert property (hresp == 1'b0)
    else $error("slave answered with an error response");

  a_analog_reads_zero: assert property (
    dphase && !st_r.wr && st_r.addr == bidio_pkg::OFS_FP_PINS
    |=> (hrdata[5:0] & $past(st_r.fp_ans)) == 6'h00)
    else $error("analog pin read back as one");

  a_fp_ans_hole: assert property (
    (st_r.fp_ans & ~bidio_pkg::FP_ANS_MASK) == 6'h00)
    else $error("unimplemented first port analog bit set");

  a_latch_readback: assert property (
    dphase && !st_r.wr && st_r.addr == bidio_pkg::OFS_FP_LAT
    |=> hrdata[5:0] == $past(st_r.fp_lat))
    else $error("latch register did not return latched value");

  a_rmw_store: assert property (
    dphase && st_r.wr && st_r.addr == bidio_pkg::OFS_TP_PINS
    |=> st_r.tp_lat == $past(rmw_tp))
    else $error("pin register write did not store merged value");

  a_tp_ans_hole: assert property (
    dphase && !st_r.wr && st_r.addr == bidio_pkg::OFS_TP_ANS
    |=> hrdata[5:4] == 2'b00)
    else $error("unimplemented analog select bits read as one");

  a_pin_analog_select_bit_reset: assert property (@(posedge mclk) disable iff (1'b0)
    sys_rst |=> st_r.fp_ans == bidio_pkg::FP_ANS_RST
                && st_r.tp_ans == bidio_pkg::TP_ANS_RST)
    else $error("analog select not analog after reset");

  a_wpu_reset: assert property (@(posedge mclk) disable iff (1'b0)
    sys_rst |=> st_r.tp_wpu == bidio_pkg::TP_WPU_RST)
    else $error("weak pull-up bits not set after reset");

  a_slew_follows: assert property (
    dphase && st_r.wr && st_r.addr == bidio_pkg::OFS_FP_SLEW
    |-> ##2 first_port_slew_limit == $past(hwdata[5:0], 2))
    else $error("slew output did not follow register write");

  // The pull-up flop is loaded from the direction of the cycle before.
  a_pullup_off_out: assert property (
    (third_port_weak_pullup_on & ~$past(st_r.tp_dir)) == 8'h00)
    else $error("pull-up on while pin drives");

  c_rmw_write: cover property (
    dphase && st_r.wr && st_r.addr == bidio_pkg::OFS_FP_PINS);
  c_analog_read: cover property (
    dphase && !st_r.wr && st_r.addr == bidio_pkg::OFS_FP_PINS && st_r.fp_ans != 6'h00);
  c_pullup_active: cover property (third_port_weak_pullup_on != 8'h00);
  c_open_drain_low: cover property ((first_port_pins_oe & st_r.fp_od) != 6'h00);

endmodule : bidio_top

// ===== core/bidio_pkg.sv
// Constants, types and shared helpers of the bidirectional I/O port block.
// Notes on behaviour
// - The first port is six pins wide; each pin but pin three may be input or output.
// - A direction bit of one makes the pin an input with its driver off.
// - A direction bit of zero enables the driver and drives the latch value.
// - First port pin three is input only; its direction bit always reads one.
// - Reading the pin register returns pin states; writing it loads the latch.
// - Every pin register write samples the pins, merges, then stores the latch.
// - Direction bits steer drivers even on analog pins; keep them input there.
// - A pin configured as analog input reads zero digitally.
// - Open-drain select makes the pin sink only; clear gives push-pull drive.
// - Slew select limits the edge rate; clear switches at full speed.
// - Threshold select picks Schmitt or TTL levels for pin reads.
// - Analog select forces digital reads of the pin to zero.
// - Analog select leaves digital output driving unchanged.
// - Analog select bits reset to analog; software clears them for digital use.
// - Third port analog select uses bits 7:6 and 3:0; bits 5:4 read zero.
// - Weak pull-ups act only while the global pull-up disable bit is clear.
// - A weak pull-up switches off while its pin is an output.
package bidio_pkg;

  localparam int FP_W = 6;
  localparam int TP_W = 8;

  localparam logic [7:0] OFS_FP_PINS = 8'h00;
  localparam logic [7:0] OFS_FP_DIR  = 8'h04;
  localparam logic [7:0] OFS_FP_LAT  = 8'h08;
  localparam logic [7:0] OFS_FP_OD   = 8'h0C;
  localparam logic [7:0] OFS_FP_SLEW = 8'h10;
  localparam logic [7:0] OFS_FP_THR  = 8'h14;
  localparam logic [7:0] OFS_FP_ANS  = 8'h18;
  localparam logic [7:0] OFS_TP_PINS = 8'h1C;
  localparam logic [7:0] OFS_TP_DIR  = 8'h20;
  localparam logic [7:0] OFS_TP_LAT  = 8'h24;
  localparam logic [7:0] OFS_TP_ANS  = 8'h28;
  localparam logic [7:0] OFS_TP_WPU  = 8'h2C;
  localparam logic [7:0] OFS_OPTION  = 8'h30;

  localparam int         GPD_BIT         = 0;
  localparam int         RMW_KEEP_LSB    = 8;
  localparam logic [5:0] FP_IN_ONLY_MASK = 6'h08;
  localparam logic [5:0] FP_ANS_MASK     = 6'h17;
  localparam logic [7:0] TP_ANS_MASK     = 8'hCF;

  localparam logic [5:0] FP_DIR_RST  = 6'h3F;
  localparam logic [5:0] FP_LAT_RST  = 6'h00;
  localparam logic [5:0] FP_OD_RST   = 6'h00;
  localparam logic [5:0] FP_SLEW_RST = 6'h00;
  localparam logic [5:0] FP_THR_RST  = 6'h3F;
  localparam logic [5:0] FP_ANS_RST  = 6'h17;
  localparam logic [7:0] TP_DIR_RST  = 8'hFF;
  localparam logic [7:0] TP_LAT_RST  = 8'h00;
  localparam logic [7:0] TP_ANS_RST  = 8'hCF;
  localparam logic [7:0] TP_WPU_RST  = 8'hFF;
  localparam logic       GPD_RST     = 1'b1;

  typedef enum logic [1:0] {
    BIDIO_IDLE = 2'b01,
    BIDIO_DATA = 2'b10
  } bidio_bus_e;

  // Bits set in keep take the sampled pin value, the others take new data.
  function automatic logic [7:0] bidio_rmw(input logic [7:0] pins,
                                           input logic [7:0] data,
                                           input logic [7:0] keep);
    return (pins & keep) | (data & ~keep);
  endfunction : bidio_rmw

endpackage : bidio_pkg

// ===== core/bidio_pad_if.sv
// Control and drive signals between the register logic and one port's pad logic.
`timescale 1ns/100ps
interface bidio_pad_if #(parameter int W = 6);
  logic [W-1:0] dir;
  logic [W-1:0] lat;
  logic [W-1:0] od;
  logic [W-1:0] pu_sel;
  logic         gpd;
  logic [W-1:0] oe;
  logic [W-1:0] out;
  logic [W-1:0] pu;
  modport ctl (output dir, lat, od, pu_sel, gpd, input oe, out, pu);
  modport pad (input dir, lat, od, pu_sel, gpd, output oe, out, pu);
endinterface : bidio_pad_if

// ===== core/bidio_sync.sv
// Two-flip-flop synchroniser for pin inputs.
`timescale 1ns/100ps
module bidio_sync #(parameter int W = 1) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bidio_sync_s;

  bidio_sync_s st_r;
  bidio_sync_s st_nxt;

  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule : bidio_sync

// ===== core/bidio_padctl.sv
// Registered output driver, open-drain and pull-up logic for one port.
`timescale 1ns/100ps
module bidio_padctl #(parameter int W = 6) (
  input wire logic mclk,
  input wire logic sys_rst,
  bidio_pad_if.pad p
);
  typedef struct packed {
    logic [W-1:0] oe;
    logic [W-1:0] out;
    logic [W-1:0] pu;
  } bidio_pad_s;

  bidio_pad_s st_r;
  bidio_pad_s st_nxt;

  always_comb begin
    // Open drain never drives high: the driver is only on while pulling low.
    st_nxt.oe  = ~p.dir & ~(p.od & p.lat);
    st_nxt.out = p.lat & ~p.od;
    st_nxt.pu  = p.pu_sel & p.dir & {W{~p.gpd}};
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign p.oe  = st_r.oe;
  assign p.out = st_r.out;
  assign p.pu  = st_r.pu;

  a_od_sink_only: assert property (@(posedge mclk) disable iff (sys_rst)
    1'b1 |=> ((p.oe & p.out & $past(p.od)) == '0))
    else $error("open-drain pin driven high");
  a_oe_follows_dir: assert property (@(posedge mclk) disable iff (sys_rst)
    1'b1 |=> ((p.oe & $past(p.dir)) == '0))
    else $error("driver on while direction is input");
  a_pullup_gated: assert property (@(posedge mclk) disable iff (sys_rst)
    $past(p.gpd) |-> (p.pu == '0))
    else $error("pull-up on while globally disabled");
endmodule : bidio_padctl

// ===== core/bidio_top_unused_placeholder_removed.sv
// Intentionally empty.
`timescale 1ns/100ps

// ===== sim/bidio_board.sv
// Board model: pin levels seen by both ports.
`timescale 1ns/100ps
module bidio_board (
  input  wire logic       mclk,
  input  wire logic [5:0] a_oe,
  input  wire logic [5:0] a_out,
  input  wire logic [5:0] a_en,
  input  wire logic [5:0] a_val,
  input  wire logic [5:0] a_mid,
  output logic      [5:0] a_st,
  output logic      [5:0] a_ttl,
  input  wire logic [7:0] c_oe,
  input  wire logic [7:0] c_out,
  input  wire logic [7:0] c_pu,
  input  wire logic [7:0] c_en,
  input  wire logic [7:0] c_val,
  output logic      [7:0] c_lvl
);
  logic [7:0] flt_r = 8'h55;
  logic [5:0] a_lvl;
  logic [5:0] a_x;
  // An undriven pin without a weak pull-up toggles so that a stale level never passes for a driven one.
  always @(posedge mclk) flt_r <= ~flt_r;
  assign a_lvl = (a_oe & a_out) | (~a_oe & ((a_en & a_val) | (~a_en & flt_r[5:0])));
  // A level between the two thresholds reads high on TTL and low on Schmitt.
  assign a_x   = a_mid & a_en & ~a_oe;
  assign a_st  = a_lvl & ~a_x;
  assign a_ttl = a_lvl | a_x;
  assign c_lvl = (c_oe & c_out) | (~c_oe & ((c_en & c_val) | (~c_en & (c_pu | flt_r))));
endmodule : bidio_board

// ===== sim/tb_bidio_top.sv
// Self-checking bench of the bidirectional I/O port block.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb_bidio_top;
  logic        mclk;
  logic        sys_rst;
  logic        hsel;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [5:0]  a_st, a_ttl, a_out, a_oe, a_slew;
  logic [5:0]  a_en, a_val, a_mid;
  logic [7:0]  c_lvl, c_out, c_oe, c_pu;
  logic [7:0]  c_en, c_val;
  int          n_fail;
  int          total_checks;

  bidio_top dut (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .first_port_pins_st(a_st), .first_port_pins_ttl(a_ttl),
    .first_port_pins_out(a_out), .first_port_pins_oe(a_oe),
    .first_port_slew_limit(a_slew), .third_port_pins_in(c_lvl),
    .third_port_pins_out(c_out), .third_port_pins_oe(c_oe),
    .third_port_weak_pullup_on(c_pu));

  bidio_board board (.mclk(mclk), .a_oe(a_oe), .a_out(a_out), .a_en(a_en),
    .a_val(a_val), .a_mid(a_mid), .a_st(a_st), .a_ttl(a_ttl), .c_oe(c_oe),
    .c_out(c_out), .c_pu(c_pu), .c_en(c_en), .c_val(c_val), .c_lvl(c_lvl));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  // Hready seen at the falling edge is what the next rising edge samples.
  task automatic wait_rdy(output logic [31:0] d);
    logic r;
    do begin
      @(negedge mclk);
      r = hreadyout;
      d = hrdata;
      @(posedge mclk);
    end while (r !== 1'b1);
  endtask : wait_rdy

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    logic [31:0] x;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy(x);
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy(rd);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, x);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(a, 1'b0, 32'h0, x);
    `CHK(nm, e, x)
    `CHK("hresp", 1'b0, hresp)
  endtask : rdc

  task automatic t_reset;
    `CHK("fp_oe", 6'h00, a_oe)
    `CHK("tp_oe", 8'h00, c_oe)
    rdc("fp_dir", bidio_pkg::OFS_FP_DIR, 32'h3F);
    rdc("fp_ans", bidio_pkg::OFS_FP_ANS, 32'h17);
    rdc("tp_ans", bidio_pkg::OFS_TP_ANS, 32'hCF);
    rdc("tp_wpu", bidio_pkg::OFS_TP_WPU, 32'hFF);
    rdc("option", bidio_pkg::OFS_OPTION, 32'h1);
    rdc("fp_thr", bidio_pkg::OFS_FP_THR, 32'h3F);
    rdc("fp_od", bidio_pkg::OFS_FP_OD, 32'h0);
    rdc("fp_slew", bidio_pkg::OFS_FP_SLEW, 32'h0);
    rdc("unmapped", 8'h3C, 32'h0);
    wr(bidio_pkg::OFS_TP_ANS, 32'hFF);
    rdc("tp_ans", bidio_pkg::OFS_TP_ANS, 32'hCF);
    wr(bidio_pkg::OFS_TP_ANS, 32'h0);
  endtask : t_reset

  task automatic t_drive;
    wr(bidio_pkg::OFS_FP_LAT, 32'h2D);
    wr(bidio_pkg::OFS_FP_ANS, 32'h3F);
    wr(bidio_pkg::OFS_FP_DIR, 32'h0);
    rdc("fp_dir", bidio_pkg::OFS_FP_DIR, 32'h08);
    rdc("fp_lat", bidio_pkg::OFS_FP_LAT, 32'h2D);
    wr(bidio_pkg::OFS_TP_LAT, 32'hA5);
    wr(bidio_pkg::OFS_TP_DIR, 32'h0);
    @(negedge mclk);
    `CHK("fp_oe", 6'h37, a_oe)
    `CHK("fp_out", 6'h2D, a_out)
    `CHK("tp_oe", 8'hFF, c_oe)
    `CHK("tp_out", 8'hA5, c_out)
    @(posedge mclk);
    wr(bidio_pkg::OFS_FP_DIR, 32'h3F);
    wr(bidio_pkg::OFS_TP_DIR, 32'hFF);
    @(negedge mclk);
    `CHK("fp_oe", 6'h00, a_oe)
    `CHK("tp_oe", 8'h00, c_oe)
    @(posedge mclk);
    wr(bidio_pkg::OFS_FP_ANS, 32'h0);
  endtask : t_drive

  task automatic t_rmw;
    a_en  <= 6'h3F;
    a_val <= 6'h2B;
    repeat (4) @(posedge mclk);
    rdc("fp_pins", bidio_pkg::OFS_FP_PINS, 32'h2B);
    wr(bidio_pkg::OFS_FP_ANS, 32'h17);
    rdc("fp_pins", bidio_pkg::OFS_FP_PINS, 32'h28);
    wr(bidio_pkg::OFS_FP_PINS, 32'h3F00);
    rdc("fp_lat", bidio_pkg::OFS_FP_LAT, 32'h28);
    wr(bidio_pkg::OFS_FP_PINS, 32'h2105);
    rdc("fp_lat", bidio_pkg::OFS_FP_LAT, 32'h24);
    rdc("fp_pins", bidio_pkg::OFS_FP_PINS, 32'h28);
    wr(bidio_pkg::OFS_FP_ANS, 32'h0);
  endtask : t_rmw

  task automatic t_od_slew;
    a_en <= 6'h00;
    wr(bidio_pkg::OFS_FP_OD, 32'h3F);
    wr(bidio_pkg::OFS_FP_LAT, 32'h05);
    wr(bidio_pkg::OFS_FP_DIR, 32'h0);
    wr(bidio_pkg::OFS_FP_SLEW, 32'h2A);
    @(negedge mclk);
    `CHK("fp_oe", 6'h32, a_oe)
    `CHK("fp_out", 6'h00, a_out)
    `CHK("slew", 6'h2A, a_slew)
    @(posedge mclk);
    wr(bidio_pkg::OFS_FP_OD, 32'h0);
    wr(bidio_pkg::OFS_FP_SLEW, 32'h0);
    @(negedge mclk);
    `CHK("fp_oe", 6'h37, a_oe)
    `CHK("fp_out", 6'h05, a_out)
    `CHK("slew", 6'h00, a_slew)
    @(posedge mclk);
    wr(bidio_pkg::OFS_FP_DIR, 32'h3F);
  endtask : t_od_slew

  task automatic t_thr;
    a_en  <= 6'h3F;
    a_val <= 6'h00;
    a_mid <= 6'h3F;
    repeat (4) @(posedge mclk);
    rdc("fp_pins", bidio_pkg::OFS_FP_PINS, 32'h0);
    wr(bidio_pkg::OFS_FP_THR, 32'h15);
    repeat (4) @(posedge mclk);
    rdc("fp_pins", bidio_pkg::OFS_FP_PINS, 32'h2A);
    a_mid <= 6'h00;
  endtask : t_thr

  task automatic t_pull;
    c_en  <= 8'h0A;
    c_val <= 8'h0A;
    wr(bidio_pkg::OFS_TP_DIR, 32'h0F);
    @(negedge mclk);
    `CHK("pullup", 8'h00, c_pu)
    @(posedge mclk);
    wr(bidio_pkg::OFS_OPTION, 32'h0);
    @(negedge mclk);
    `CHK("pullup", 8'h0F, c_pu)
    `CHK("tp_oe", 8'hF0, c_oe)
    @(posedge mclk);
    wr(bidio_pkg::OFS_TP_WPU, 32'h05);
    repeat (4) @(posedge mclk);
    // Driven high nibble shows the latch A5, the low nibble board and pull-ups.
    rdc("tp_pins", bidio_pkg::OFS_TP_PINS, 32'hAF);
    wr(bidio_pkg::OFS_TP_PINS, 32'h0F30);
    rdc("tp_lat", bidio_pkg::OFS_TP_LAT, 32'h3F);
    @(negedge mclk);
    `CHK("pullup", 8'h05, c_pu)
    @(posedge mclk);
    wr(bidio_pkg::OFS_OPTION, 32'h1);
    @(negedge mclk);
    `CHK("pullup", 8'h00, c_pu)
  endtask : t_pull

  // A reset in mid-run must bring the pull-up, analog select, threshold, third port latch and option registers back to reset.
  task automatic t_midrst;
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    `CHK("tp_oe", 8'h00, c_oe)
    rdc("tp_wpu", bidio_pkg::OFS_TP_WPU, 32'hFF);
    rdc("fp_ans", bidio_pkg::OFS_FP_ANS, 32'h17);
    rdc("tp_ans", bidio_pkg::OFS_TP_ANS, 32'hCF);
    rdc("fp_thr", bidio_pkg::OFS_FP_THR, 32'h3F);
    rdc("tp_lat", bidio_pkg::OFS_TP_LAT, 32'h00);
    rdc("option", bidio_pkg::OFS_OPTION, 32'h1);
  endtask : t_midrst

  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    complete_run();
  end

  initial begin
    n_fail = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    hsel = 1'b1;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    a_en = 6'h00;
    a_val = 6'h00;
    a_mid = 6'h00;
    c_en = 8'h00;
    c_val = 8'h00;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge mclk);
    t_reset();
    t_drive();
    t_rmw();
    t_od_slew();
    t_thr();
    t_pull();
    t_midrst();
    complete_run();
  end
endmodule : tb_bidio_top
